// ### uoe_event_status.sv
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - stall flag: host receives stall, device sends stall, handshake phase
// - attach flag only with host enabled, bus quiet 2.5 us, not SE0
// - resume flag when K state holds 2.5 us
// - idle flag after 3 ms of continuous idle bus
// - token complete flag set at token end; status shows endpoint info
// - clearing token complete flag advances the status FIFO
// - frame flag: device receives frame token, host reaches threshold
// - summary error flag read-only, set only by enabled errors
// - device mode: bit 0 set on valid bus reset
// - host mode: bit 0 set on peripheral detach
// - flags reset zero, hardware set, write one clears, upper bits zero
// - device mode: token CRC5 failure flags an error
// - host mode: end-of-frame error when frame counter hits zero mid-transfer
// - packet id check failure flags an error
// - turnaround error after more than 16 idle bit times since EOP
// - memory-access error on late grant or truncated packet
// - ping-pong reset forces all buffer pointers to even bank
// - device mode: control bit 0 enables the module
// - host mode: frame token every 1 ms when enabled, none otherwise
// - resume held 10/25 ms by software; host appends low-speed EOP on release
// - host control logic reset whenever host control bit changes
module uoe_event_status (
    // clock and reset
    input wire logic SYS_CLK_IN,
    input wire logic RST_IN,
    // register port
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [31:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    output logic [31:0] REG_RDATA_OUT,
    // bus line state pins
    input wire logic BUS_SE0_IN,
    input wire logic BUS_K_IN,
    input wire logic BUS_IDLE_IN,
    // protocol engine events
    input wire logic STALL_HS_IN,
    input wire logic TOKEN_DONE_IN,
    input wire logic [7:0] TOKEN_STAT_IN,
    input wire logic FRAME_TOKEN_RX_IN,
    input wire logic BUS_RESET_IN,
    input wire logic CRC5_FAIL_IN,
    input wire logic PID_FAIL_IN,
    input wire logic EOP_IN,
    input wire logic XFER_ACTIVE_IN,
    input wire logic DMA_LATE_IN,
    input wire logic PKT_TRUNC_IN,
    // controls and status out
    output logic IRQ_OUT,
    output logic MODULE_EN_OUT,
    output logic PINGPONG_RESET_OUT,
    output logic FRAME_TOKEN_SEND_OUT,
    output logic RESUME_DRIVE_OUT,
    output logic LS_EOP_SEND_OUT,
    output logic HOST_LOGIC_RESET_OUT
);
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [2:0] pin_meta_reg;
    logic [2:0] pin_sync_reg;
    logic se0_s;
    logic k_s;
    logic idle_s;
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            pin_meta_reg <= 3'h0;
            pin_sync_reg <= 3'h0;
        end else begin
            pin_meta_reg <= {BUS_IDLE_IN, BUS_K_IN, BUS_SE0_IN};
            pin_sync_reg <= pin_meta_reg;
        end
    end
    assign se0_s = pin_sync_reg[0];
    assign k_s = pin_sync_reg[1];
    assign idle_s = pin_sync_reg[2];
    // previous synchronised se0 level for the detach edge
    logic se0_prev_reg;
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            se0_prev_reg <= 1'b0;
        end else begin
            se0_prev_reg <= se0_s;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] evt_flags_reg;
    logic [7:0] evt_next;
    logic [7:0] evt_enable_reg;
    logic [7:0] err_flags_reg;
    logic [7:0] err_next;
    logic [7:0] err_enable_reg;
    logic [7:0] control_reg;
    logic host_en;
    logic host_prev_reg;
    logic frame_en;
    logic [7:0] set_evt;
    logic [7:0] set_err;
    logic [7:0] stat_head;
    logic stat_empty;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    logic wr_evt;
    logic wr_err;
    logic wr_ctl;
    assign wr_evt = REG_WR_IN && hit(REG_ADDR_IN, uoe_pkg::EVT_FLAGS_OFS);
    assign wr_err = REG_WR_IN && hit(REG_ADDR_IN, uoe_pkg::ERR_FLAGS_OFS);
    assign wr_ctl = REG_WR_IN && hit(REG_ADDR_IN, uoe_pkg::CONTROL_OFS);
    assign host_en = control_reg[uoe_pkg::CTL_HOST_BIT];
    assign frame_en = control_reg[uoe_pkg::CTL_FRAME_BIT];

    // ----------------------------------------
    // bus timers
    // ----------------------------------------
    logic attach_hit;
    logic resume_hit;
    logic idle_hit;
    logic turn_hit;
    uoe_level_timer attach_timer (
        .clk_in(SYS_CLK_IN),
        .rst_in(RST_IN),
        .level_in(host_en && idle_s && !se0_s),
        .limit_in(uoe_pkg::CNT_W'(uoe_pkg::BUS_QUIET_CYC)),
        .reached_out(attach_hit)
    );
    uoe_level_timer resume_timer (
        .clk_in(SYS_CLK_IN),
        .rst_in(RST_IN),
        .level_in(k_s),
        .limit_in(uoe_pkg::CNT_W'(uoe_pkg::BUS_QUIET_CYC)),
        .reached_out(resume_hit)
    );
    uoe_level_timer idle_timer (
        .clk_in(SYS_CLK_IN),
        .rst_in(RST_IN),
        .level_in(idle_s),
        .limit_in(uoe_pkg::CNT_W'(uoe_pkg::IDLE_CYC)),
        .reached_out(idle_hit)
    );

    // turnaround window opens at each end-of-packet, closes on any activity
    logic turn_arm_reg;
    logic [15:0] turn_cnt_reg;
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            turn_arm_reg <= 1'b0;
            turn_cnt_reg <= 16'h0000;
        end else if (EOP_IN) begin
            turn_arm_reg <= 1'b1;
            turn_cnt_reg <= 16'h0000;
        end else if (turn_arm_reg && !idle_s) begin
            turn_arm_reg <= 1'b0;
        end else if (turn_arm_reg) begin
            turn_cnt_reg <= turn_cnt_reg + 16'h0001;
            if (turn_cnt_reg == 16'(uoe_pkg::TURN_CYC)) begin
                turn_arm_reg <= 1'b0;
            end
        end
    end
    assign turn_hit = turn_arm_reg && idle_s && !EOP_IN
        && (turn_cnt_reg == 16'(uoe_pkg::TURN_CYC));

    // ----------------------------------------
    // host frame counter
    // ----------------------------------------
    logic [16:0] frame_cnt_reg;
    logic frame_zero;
    assign frame_zero = (frame_cnt_reg == 17'h00000);
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            frame_cnt_reg <= 17'(uoe_pkg::FRAME_CYC - 1);
        end else if (!host_en || !frame_en || (host_en != host_prev_reg)) begin
            frame_cnt_reg <= 17'(uoe_pkg::FRAME_CYC - 1);
        end else if (frame_zero) begin
            frame_cnt_reg <= 17'(uoe_pkg::FRAME_CYC - 1);
        end else begin
            frame_cnt_reg <= frame_cnt_reg - 17'h00001;
        end
    end
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            FRAME_TOKEN_SEND_OUT <= 1'b0;
        end else begin
            FRAME_TOKEN_SEND_OUT <= host_en && frame_en && frame_zero;
        end
    end

    // ----------------------------------------
    // error flags
    // ----------------------------------------
    always_comb begin
        set_err = 8'h00;
        set_err[uoe_pkg::ERR_PID_BIT] = PID_FAIL_IN;
        set_err[uoe_pkg::ERR_CRC_EOF_BIT] = host_en
            ? (frame_zero && frame_en && XFER_ACTIVE_IN)
            : CRC5_FAIL_IN;
        set_err[uoe_pkg::ERR_TURN_BIT] = turn_hit;
        set_err[uoe_pkg::ERR_DMA_BIT] = DMA_LATE_IN || PKT_TRUNC_IN;
    end
    always_comb begin
        err_next = err_flags_reg;
        if (wr_err) begin
            err_next = err_next & ~REG_WDATA_IN[7:0];
        end
        err_next = err_next | set_err;
    end
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            err_flags_reg <= uoe_pkg::RESET_VALUE_8;
        end else begin
            err_flags_reg <= err_next;
        end
    end

    // ----------------------------------------
    // event flags
    // ----------------------------------------
    always_comb begin
        set_evt = 8'h00;
        set_evt[uoe_pkg::EVT_STALL_BIT] = STALL_HS_IN;
        set_evt[uoe_pkg::EVT_ATTACH_BIT] = attach_hit;
        set_evt[uoe_pkg::EVT_RESUME_BIT] = resume_hit;
        set_evt[uoe_pkg::EVT_IDLE_BIT] = idle_hit;
        set_evt[uoe_pkg::EVT_TOKEN_BIT] = TOKEN_DONE_IN;
        set_evt[uoe_pkg::EVT_FRAME_BIT] = host_en
            ? (frame_en && frame_zero) : FRAME_TOKEN_RX_IN;
        set_evt[uoe_pkg::EVT_RESET_BIT] = host_en
            ? (host_prev_reg && se0_s && !se0_prev_reg)
            : BUS_RESET_IN;
    end
    always_comb begin
        evt_next = evt_flags_reg;
        if (wr_evt) begin
            evt_next = evt_next & ~REG_WDATA_IN[7:0];
        end
        evt_next = evt_next | set_evt;
        // summary bit follows enabled errors only, never written
        evt_next[uoe_pkg::EVT_ERROR_BIT] = |(err_next & err_enable_reg);
    end
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            evt_flags_reg <= uoe_pkg::RESET_VALUE_8;
        end else begin
            evt_flags_reg <= evt_next;
        end
    end

    // ----------------------------------------
    // transfer status fifo
    // ----------------------------------------
    logic stat_pop;
    assign stat_pop = wr_evt && REG_WDATA_IN[uoe_pkg::EVT_TOKEN_BIT]
        && evt_flags_reg[uoe_pkg::EVT_TOKEN_BIT];
    uoe_stat_fifo stat_fifo (
        .clk_in(SYS_CLK_IN),
        .rst_in(RST_IN),
        .push_in(TOKEN_DONE_IN),
        .push_data_in(TOKEN_STAT_IN),
        .pop_in(stat_pop),
        .head_out(stat_head),
        .empty_out(stat_empty)
    );

    // ----------------------------------------
    // control and enables
    // ----------------------------------------
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            control_reg <= uoe_pkg::RESET_VALUE_8;
            evt_enable_reg <= uoe_pkg::RESET_VALUE_8;
            err_enable_reg <= uoe_pkg::RESET_VALUE_8;
        end else begin
            if (wr_ctl) begin
                control_reg <= REG_WDATA_IN[7:0];
            end
            if (REG_WR_IN && hit(REG_ADDR_IN, uoe_pkg::EVT_ENABLE_OFS)) begin
                evt_enable_reg <= REG_WDATA_IN[7:0];
            end
            if (REG_WR_IN && hit(REG_ADDR_IN, uoe_pkg::ERR_ENABLE_OFS)) begin
                err_enable_reg <= REG_WDATA_IN[7:0];
            end
        end
    end

    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            host_prev_reg <= 1'b0;
            HOST_LOGIC_RESET_OUT <= 1'b0;
        end else begin
            host_prev_reg <= host_en;
            HOST_LOGIC_RESET_OUT <= (host_en != host_prev_reg);
        end
    end

    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            MODULE_EN_OUT <= 1'b0;
            PINGPONG_RESET_OUT <= 1'b0;
            RESUME_DRIVE_OUT <= 1'b0;
            LS_EOP_SEND_OUT <= 1'b0;
        end else begin
            // bit 0 doubles as module enable outside host mode
            MODULE_EN_OUT <= !host_en && control_reg[uoe_pkg::CTL_FRAME_BIT];
            PINGPONG_RESET_OUT <= control_reg[uoe_pkg::CTL_PPRST_BIT];
            RESUME_DRIVE_OUT <= control_reg[uoe_pkg::CTL_RESUME_BIT];
            LS_EOP_SEND_OUT <= host_en && RESUME_DRIVE_OUT
                && !control_reg[uoe_pkg::CTL_RESUME_BIT];
        end
    end

    // ----------------------------------------
    // interrupt and read port
    // ----------------------------------------
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            IRQ_OUT <= 1'b0;
        end else begin
            IRQ_OUT <= |(evt_flags_reg & evt_enable_reg);
        end
    end

    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            REG_RDATA_OUT <= 32'h0000_0000;
        end else if (REG_RD_IN) begin
            case (REG_ADDR_IN)
                uoe_pkg::EVT_FLAGS_OFS: REG_RDATA_OUT <= {24'h000000, evt_flags_reg};
                uoe_pkg::EVT_ENABLE_OFS: REG_RDATA_OUT <= {24'h000000, evt_enable_reg};
                uoe_pkg::ERR_FLAGS_OFS: REG_RDATA_OUT <= {24'h000000, err_flags_reg};
                uoe_pkg::ERR_ENABLE_OFS: REG_RDATA_OUT <= {24'h000000, err_enable_reg};
                uoe_pkg::CONTROL_OFS: REG_RDATA_OUT <= {24'h000000, control_reg};
                uoe_pkg::XFER_STATUS_OFS: begin
                    REG_RDATA_OUT <= {23'h000000, stat_empty, stat_empty ? 8'h00 : stat_head};
                end
                default: REG_RDATA_OUT <= 32'h0000_0000;
            endcase
        end else begin
            REG_RDATA_OUT <= 32'h0000_0000;
        end
    end
endmodule
`default_nettype wire

// ### uoe_pkg.sv
package uoe_pkg;
    // ----------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] EVT_FLAGS_OFS = 8'h00;
    localparam logic [7:0] EVT_ENABLE_OFS = 8'h04;
    localparam logic [7:0] ERR_FLAGS_OFS = 8'h08;
    localparam logic [7:0] ERR_ENABLE_OFS = 8'h0C;
    localparam logic [7:0] CONTROL_OFS = 8'h10;
    localparam logic [7:0] XFER_STATUS_OFS = 8'h14;
    // ----------------------------------------
    // event flag positions
    // ----------------------------------------
    localparam int EVT_STALL_BIT = 7;
    localparam int EVT_ATTACH_BIT = 6;
    localparam int EVT_RESUME_BIT = 5;
    localparam int EVT_IDLE_BIT = 4;
    localparam int EVT_TOKEN_BIT = 3;
    localparam int EVT_FRAME_BIT = 2;
    localparam int EVT_ERROR_BIT = 1;
    localparam int EVT_RESET_BIT = 0;
    // ----------------------------------------
    // error flag positions
    // ----------------------------------------
    localparam int ERR_DMA_BIT = 5;
    localparam int ERR_TURN_BIT = 4;
    localparam int ERR_CRC_EOF_BIT = 1;
    localparam int ERR_PID_BIT = 0;
    // ----------------------------------------
    // control bit positions
    // ----------------------------------------
    localparam int CTL_FRAME_BIT = 0;
    localparam int CTL_PPRST_BIT = 1;
    localparam int CTL_RESUME_BIT = 2;
    localparam int CTL_HOST_BIT = 3;
    localparam logic [7:0] RESET_VALUE_8 = 8'h00;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int BUS_QUIET_NS = 2500;
    localparam int BUS_QUIET_CYC = BUS_QUIET_NS * CLK_MHZ / 1000;
    localparam int IDLE_MS = 3;
    localparam int IDLE_CYC = IDLE_MS * CLK_MHZ * 1000;
    localparam int FRAME_MS = 1;
    localparam int FRAME_CYC = FRAME_MS * CLK_MHZ * 1000;
    localparam int TURN_BIT_TIMES = 16;
    localparam int FS_BIT_NS = 83;
    localparam int TURN_CYC = TURN_BIT_TIMES * FS_BIT_NS * CLK_MHZ / 1000;
    localparam int STAT_DEPTH = 4;
    localparam int CNT_W = 24;
endpackage

// ### uoe_level_timer.sv
`timescale 1ns/1ps
`default_nettype none
module uoe_level_timer (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // condition and limit
    input wire logic level_in,
    input wire logic [uoe_pkg::CNT_W-1:0] limit_in,
    // result
    output logic reached_out
);
    logic [uoe_pkg::CNT_W-1:0] count_reg;
    // counts cycles of an unbroken level; pulses once when limit is met
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_reg <= '0;
            reached_out <= 1'b0;
        end else if (!level_in) begin
            count_reg <= '0;
            reached_out <= 1'b0;
        end else begin
            if (count_reg != limit_in) begin
                count_reg <= count_reg + 1'b1;
            end
            reached_out <= (count_reg == limit_in - 1'b1);
        end
    end
endmodule
`default_nettype wire

// ### uoe_stat_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module uoe_stat_fifo (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // push and pop
    input wire logic push_in,
    input wire logic [7:0] push_data_in,
    input wire logic pop_in,
    // head
    output logic [7:0] head_out,
    output logic empty_out
);
    logic [7:0] mem_reg [uoe_pkg::STAT_DEPTH];
    logic [1:0] rd_reg;
    logic [1:0] wr_reg;
    logic [2:0] cnt_reg;
    logic do_push;
    logic do_pop;
    assign do_push = push_in && (cnt_reg != 3'(uoe_pkg::STAT_DEPTH));
    assign do_pop = pop_in && (cnt_reg != 3'h0);
    assign head_out = mem_reg[rd_reg];
    assign empty_out = (cnt_reg == 3'h0);
    always_ff @(posedge clk_in) begin
        if (do_push) begin
            mem_reg[wr_reg] <= push_data_in;
        end
    end
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_reg <= 2'h0;
            wr_reg <= 2'h0;
            cnt_reg <= 3'h0;
        end else begin
            if (do_push) begin
                wr_reg <= wr_reg + 2'h1;
            end
            if (do_pop) begin
                rd_reg <= rd_reg + 2'h1;
            end
            cnt_reg <= cnt_reg + 3'(do_push) - 3'(do_pop);
        end
    end
endmodule
`default_nettype wire

// ### uoe_event_status_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module uoe_event_status_assertions (
    // clock, reset and register port
    input wire logic SYS_CLK_IN,
    input wire logic RST_IN,
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [31:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic [31:0] REG_RDATA_OUT,
    // events and controls
    input wire logic STALL_HS_IN,
    input wire logic DMA_LATE_IN,
    input wire logic MODULE_EN_OUT,
    input wire logic PINGPONG_RESET_OUT,
    input wire logic FRAME_TOKEN_SEND_OUT,
    input wire logic RESUME_DRIVE_OUT,
    input wire logic LS_EOP_SEND_OUT,
    input wire logic HOST_LOGIC_RESET_OUT
);
    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (RST_IN);
    logic ctl_wr;
    assign ctl_wr = REG_WR_IN && REG_ADDR_IN == uoe_pkg::CONTROL_OFS;
    sequence s_stall_rd;
        STALL_HS_IN ##1 (REG_RD_IN && REG_ADDR_IN == uoe_pkg::EVT_FLAGS_OFS);
    endsequence
    sequence s_dma_rd;
        DMA_LATE_IN ##1 (REG_RD_IN && REG_ADDR_IN == uoe_pkg::ERR_FLAGS_OFS);
    endsequence
    a_rdata_idle_zero: assert property (!REG_RD_IN |=> REG_RDATA_OUT == 32'h0)
        else $error("read data not zero outside a read");
    a_upper_bits_zero: assert property (REG_RD_IN |=> REG_RDATA_OUT[31:9] == 23'h0)
        else $error("upper read bits not zero");
    a_unmapped_reads_zero: assert property (REG_RD_IN && (REG_ADDR_IN > uoe_pkg::XFER_STATUS_OFS
        || REG_ADDR_IN[1:0] != 2'h0) |=> REG_RDATA_OUT == 32'h0)
        else $error("unmapped read not zero");
    a_stall_flag_set: assert property (s_stall_rd |=> REG_RDATA_OUT[uoe_pkg::EVT_STALL_BIT])
        else $error("stall flag missing");
    a_dma_error_set: assert property (s_dma_rd |=> REG_RDATA_OUT[uoe_pkg::ERR_DMA_BIT])
        else $error("memory access error missing");
    a_pingpong_follows: assert property (ctl_wr && REG_WDATA_IN[1] |-> ##[1:2] PINGPONG_RESET_OUT)
        else $error("pingpong reset not driven");
    a_module_enable: assert property (ctl_wr && REG_WDATA_IN[0] && !REG_WDATA_IN[3]
        |-> ##[1:2] MODULE_EN_OUT)
        else $error("module enable not driven");
    a_frame_off_quiet: assert property (ctl_wr && !REG_WDATA_IN[0]
        |-> ##2 (!FRAME_TOKEN_SEND_OUT)[*4])
        else $error("frame token sent while disabled");
    a_resume_drive: assert property (ctl_wr && REG_WDATA_IN[2] |-> ##[1:2] RESUME_DRIVE_OUT)
        else $error("resume signalling not driven");
    a_eop_after_resume: assert property (LS_EOP_SEND_OUT |-> !RESUME_DRIVE_OUT
        ##1 !LS_EOP_SEND_OUT)
        else $error("low speed eop misplaced");
    a_host_reset_pulse: assert property (HOST_LOGIC_RESET_OUT && !ctl_wr |=> !HOST_LOGIC_RESET_OUT)
        else $error("host logic reset longer than one cycle");
endmodule
bind uoe_event_status uoe_event_status_assertions i_chk (.SYS_CLK_IN, .RST_IN, .REG_ADDR_IN,
    .REG_WDATA_IN, .REG_WR_IN, .REG_RD_IN, .REG_RDATA_OUT, .STALL_HS_IN, .DMA_LATE_IN,
    .MODULE_EN_OUT, .PINGPONG_RESET_OUT, .FRAME_TOKEN_SEND_OUT, .RESUME_DRIVE_OUT,
    .LS_EOP_SEND_OUT, .HOST_LOGIC_RESET_OUT);
`default_nettype wire

// ### uoe_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module uoe_far_model (
    // clock
    input wire logic clk_in,
    // bus line levels
    output logic se0_out,
    output logic k_out,
    output logic idle_out,
    // engine events: stall, token, frame, reset, crc, pid, eop, dma, trunc
    output logic [8:0] ev_out,
    output logic [7:0] stat_out,
    output logic active_out
);
    initial begin
        se0_out = 1'b0;
        k_out = 1'b0;
        idle_out = 1'b0;
        ev_out = 9'h000;
        stat_out = 8'h00;
        active_out = 1'b0;
    end
    // one-cycle event with its endpoint byte, byte not held afterwards
    task automatic fire(input int idx, input logic [7:0] stat);
        ev_out <= 9'h001 << idx;
        stat_out <= stat;
        @(posedge clk_in);
        ev_out <= 9'h000;
        stat_out <= ~stat;
    endtask
    // line state change: se0, k, idle
    task automatic lines(input logic se0, input logic k, input logic idle);
        se0_out <= se0;
        k_out <= k;
        idle_out <= idle;
    endtask
endmodule
`default_nettype wire

// ### uoe_event_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
module uoe_event_status_tb;
    localparam logic [7:0] EF = uoe_pkg::EVT_FLAGS_OFS;
    localparam logic [7:0] EE = uoe_pkg::EVT_ENABLE_OFS;
    localparam logic [7:0] RF = uoe_pkg::ERR_FLAGS_OFS;
    localparam logic [7:0] RE = uoe_pkg::ERR_ENABLE_OFS;
    localparam logic [7:0] CT = uoe_pkg::CONTROL_OFS;
    localparam logic [7:0] ST = uoe_pkg::XFER_STATUS_OFS;
    logic clk, rst, wr_s, rd_s, irq, men, ppr, fts, rsd, lse, hlr, se0, k, idl, act;
    logic [7:0] addr, stv;
    logic [31:0] wdata, rdata, m;
    logic [8:0] ev;
    int num_errors, comparisons, hr_cnt, eop_cnt, fr_cnt;
    int src[7] = '{0, 2, 3, 4, 5, 7, 8};
    int pos[7] = '{7, 2, 0, 1, 0, 5, 5};
    uoe_far_model i_far (.clk_in(clk), .se0_out(se0), .k_out(k), .idle_out(idl),
        .ev_out(ev), .stat_out(stv), .active_out(act));
    uoe_event_status i_dut (.SYS_CLK_IN(clk), .RST_IN(rst), .REG_ADDR_IN(addr),
        .REG_WDATA_IN(wdata), .REG_WR_IN(wr_s), .REG_RD_IN(rd_s), .REG_RDATA_OUT(rdata),
        .BUS_SE0_IN(se0), .BUS_K_IN(k), .BUS_IDLE_IN(idl), .STALL_HS_IN(ev[0]),
        .TOKEN_DONE_IN(ev[1]), .TOKEN_STAT_IN(stv), .FRAME_TOKEN_RX_IN(ev[2]),
        .BUS_RESET_IN(ev[3]), .CRC5_FAIL_IN(ev[4]), .PID_FAIL_IN(ev[5]), .EOP_IN(ev[6]),
        .XFER_ACTIVE_IN(act), .DMA_LATE_IN(ev[7]), .PKT_TRUNC_IN(ev[8]), .IRQ_OUT(irq),
        .MODULE_EN_OUT(men), .PINGPONG_RESET_OUT(ppr), .FRAME_TOKEN_SEND_OUT(fts),
        .RESUME_DRIVE_OUT(rsd), .LS_EOP_SEND_OUT(lse), .HOST_LOGIC_RESET_OUT(hlr));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // pulse counters for one-cycle outputs
    always @(posedge clk) begin
        if (hlr === 1'b1) hr_cnt <= hr_cnt + 1;
        if (lse === 1'b1) eop_cnt <= eop_cnt + 1;
        if (fts === 1'b1) fr_cnt <= fr_cnt + 1;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 v = rdata;
        @(posedge clk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        check(v, exp);
    endtask
    // bit clear after lo cycles, then set within hi reads
    task automatic poll(input logic [7:0] a, input int b, input int lo, input int hi);
        logic [31:0] v;
        int n;
        repeat (lo) @(posedge clk);
        rd(a, v);
        check({31'h0, v[b]}, 32'h0);
        n = 0;
        while (v[b] !== 1'b1 && n < hi) begin
            rd(a, v);
            n++;
        end
        check({31'h0, v[b]}, 32'h1);
        if (v[b] !== 1'b1) close_out();
    endtask
    task automatic close_out();
        $display("counts: %0d comparisons, %0d mismatches", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        close_out();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        {wr_s, rd_s, addr, wdata} = '0;
        {num_errors, comparisons, hr_cnt, eop_cnt, fr_cnt} = '0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 5; i++) rdc(8'(4 * i), 32'h0);
        rdc(ST, 32'h100);
        rdc(8'h18, 32'h0);
        rdc(8'h02, 32'h0);
        $display("test reset values done");
        wr(EE, 32'h08); // token interrupt only, resume stays masked
        for (int i = 0; i < 7; i++) begin
            if (i == 3) begin
                wr(RE, 32'h0);
                i_far.fire(5, 8'h00);
                rdc(EF, 32'h0);
                wr(RE, 32'h33);
                rdc(EF, 32'h2);
                wr(EF, 32'h2);
                rdc(EF, 32'h2);
                wr(RF, 32'h1);
                rdc(EF, 32'h0);
            end
            m = 32'h1 << pos[i];
            i_far.fire(src[i], 8'h00);
            rdc((i < 3) ? EF : RF, m);
            if (i > 2) rdc(EF, 32'h2);
            wr((i < 3) ? EF : RF, 32'h0);
            rdc((i < 3) ? EF : RF, m);
            wr((i < 3) ? EF : RF, m);
            rdc((i < 3) ? EF : RF, 32'h0);
        end
        $display("test event and error flags done");
        i_far.fire(1, 8'h5A);
        i_far.fire(1, 8'hA4); // second token fires the next cycle and queues behind the first
        rdc(EF, 32'h08);
        check({31'h0, irq}, 32'h1);
        rdc(ST, 32'h5A);
        wr(EF, 32'h08);
        rdc(ST, 32'hA4);
        wr(EF, 32'h08);
        wr(EF, 32'h08);
        check({31'h0, irq}, 32'h0);
        $display("test token status done");
        i_far.lines(1'b0, 1'b0, 1'b1);
        repeat (3) @(posedge clk); // let the idle level pass the synchroniser
        i_far.fire(6, 8'h00);
        poll(RF, uoe_pkg::ERR_TURN_BIT, 120, 40);
        wr(RF, 32'h10);
        i_far.lines(1'b0, 1'b1, 1'b0);
        poll(EF, uoe_pkg::EVT_RESUME_BIT, 250, 60);
        wr(EF, 32'h20);
        $display("test bus timing done");
        wr(CT, 32'h03);
        @(negedge clk);
        check({30'h0, men, ppr}, 32'h3);
        @(posedge clk);
        wr(CT, 32'h08);
        repeat (3) @(negedge clk);
        check({30'h0, men, ppr}, 32'h0);
        check(32'(hr_cnt), 32'h1);
        @(posedge clk);
        i_far.lines(1'b1, 1'b0, 1'b0);
        poll(EF, uoe_pkg::EVT_RESET_BIT, 0, 5);
        i_far.lines(1'b0, 1'b0, 1'b1);
        poll(EF, uoe_pkg::EVT_ATTACH_BIT, 250, 60);
        wr(CT, 32'h0C);
        wr(CT, 32'h08);
        wr(CT, 32'h00);
        repeat (3) @(negedge clk);
        check({31'h0, rsd}, 32'h0);
        check(32'(eop_cnt), 32'h1);
        check(32'(hr_cnt), 32'h2);
        check(32'(fr_cnt), 32'h0);
        $display("test control and host done");
        close_out();
    end
endmodule
`default_nettype wire
